// ===== core/dmps_port.sv
// Dual mode microport slave top level.
`timescale 1ns/1ns
`include "dmps_defines.svh"
// Operation
// - Separate mode latency from read or store strobe fall
// - Separate fast addresses ready within three clocks
// - Separate address 4 and control 0: four
// - Separate address 0 RAM: five clocks
// - Strobe mode latency to acknowledge fall
// - Strobe fast addresses acknowledged within four clocks
// - Strobe addresses 4, 5, control 0: five
// - Strobe address 0 RAM: six clocks
// - Mode pin one selects data strobe
// - Shared strobe is read or data strobe
// - Acknowledge output is open drain
// - Strobes ignored without chip select
// - Low reset resets; open input inactive
module dmps_port
	import dmps_pkg::*;
(
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     bus_mode_i,
	input  wire logic                     chip_select_n_i,
	input  wire logic                     data_strobe_n_i,
	input  wire logic                     store_strobe_n_i,
	input  wire logic [`DMPS_ADDR_W-1:0]  addr_i,
	input  wire logic                     ram_target_i,
	input  wire logic [`DMPS_DATA_W-1:0]  port_data_i,
	output logic [`DMPS_DATA_W-1:0]       port_data_o,
	output logic                          port_data_oe_o,
	output logic                          ack_o,
	output logic                          ack_oe_o,
	output logic                          wr_stb_o,
	output logic                          rd_stb_o,
	output logic [`DMPS_ADDR_W-1:0]       core_addr_o,
	output logic [`DMPS_DATA_W-1:0]       core_wdata_o,
	input  wire logic [`DMPS_DATA_W-1:0]  core_rdata_i
);
	// ------------------------------------------------------------
	// Strobe decode
	// ------------------------------------------------------------
	dmps_state_t  state_q, state_d;
	dmps_access_t acc_q;
	logic [2:0]   cnt_q;
	logic         ds_mode_q;
	logic [7:0]   rdata_q;
	logic [2:0]   lat;
	function automatic logic wait_done(input dmps_state_t st, input logic [2:0] cnt);
		return (st == DMPS_WAIT) && (cnt == 3'h1);
	endfunction : wait_done
	wire last_wait = wait_done(state_q, cnt_q);
	wire wr_fire   = last_wait && acc_q.write;
	wire rd_fire   = last_wait && !acc_q.write;
	wire ds_mode  = (bus_mode_i == `DMPS_MODE_DSTROBE);
	wire sel      = !chip_select_n_i;
	wire rd_req   = sel && !data_strobe_n_i && !ds_mode;
	wire ds_req   = sel && !data_strobe_n_i && ds_mode;
	wire wr_req   = sel && !store_strobe_n_i && !ds_mode;
	wire start    = (state_q == DMPS_IDLE) && (rd_req || wr_req || ds_req);
	wire [2:0] cnt_d = start ? lat : ((cnt_q != 3'h0) ? 3'(cnt_q - 3'h1) : cnt_q);
	wire st_write = ds_mode ? !store_strobe_n_i : wr_req; // store line is read/write in strobe mode
	wire strobe_on = ds_mode_q ? (sel && !data_strobe_n_i)
		: (sel && (acc_q.write ? !store_strobe_n_i : !data_strobe_n_i));
	dmps_access_t acc_new;
	assign acc_new = '{addr: addr_i, write: st_write, ram: ram_target_i};
	// ------------------------------------------------------------
	// Latency lookup
	// ------------------------------------------------------------
	dmps_latency dmps_latency_inst (
		.mode_i (ds_mode),
		.acc_i  (acc_new),
		.lat_o  (lat)
	);
	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			DMPS_IDLE: if (start) state_d = DMPS_WAIT;
			DMPS_WAIT: if (last_wait) state_d = DMPS_ACK;
			DMPS_ACK:  if (!strobe_on) state_d = DMPS_IDLE;
			default:   state_d = DMPS_IDLE;
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_q <= DMPS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
	// ------------------------------------------------------------
	// Access capture
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			acc_q     <= '0;
			ds_mode_q <= 1'b0;
		end else if (start) begin
			acc_q     <= acc_new;
			ds_mode_q <= ds_mode;
		end
	end
	// ------------------------------------------------------------
	// Wait counter
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
		end else if (rd_fire) begin
			rdata_q <= core_rdata_i;
		end
	end
	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	wire in_ack   = (state_q == DMPS_ACK);
	wire busy_sep = !ds_mode_q && (state_q == DMPS_WAIT);
	wire done_ds  = ds_mode_q && in_ack;
	// Ready is low while busy in separate mode; acknowledge is low when done in strobe mode.
	assign ack_o    = 1'b0;
	assign ack_oe_o = busy_sep || done_ds;
	assign port_data_o    = rdata_q;
	assign port_data_oe_o = in_ack && !acc_q.write && strobe_on;
	assign wr_stb_o     = wr_fire;
	assign rd_stb_o     = rd_fire;
	assign core_addr_o  = acc_q.addr;
	assign core_wdata_o = port_data_i;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_fast_sep_ready: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && !ds_mode && lat == `DMPS_LAT_FAST_CYC |-> ##3 in_ack
	) else $error("fast ready late");
	chk_med_sep_ready: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && !ds_mode && lat == `DMPS_LAT_MED_CYC |-> ##4 in_ack
	) else $error("medium ready late");
	chk_slow_sep_ready: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && !ds_mode && lat == `DMPS_LAT_SLOW_CYC |-> ##5 in_ack
	) else $error("slow ready late");
	chk_ds_ack_bound: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && ds_mode |-> ##[4:6] (in_ack && ack_oe_o)
	) else $error("acknowledge late");
	chk_ds_ram_lat: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && ds_mode && addr_i == 3'h0 && ram_target_i |-> ##6 in_ack
	) else $error("ram ack timing");
	chk_ds_med_lat: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && ds_mode && addr_i == 3'h5 |-> ##5 in_ack
	) else $error("address five timing");
	chk_no_cs_idle: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == DMPS_IDLE && chip_select_n_i |=> state_q == DMPS_IDLE
	) else $error("start without select");
	chk_data_drive: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		port_data_oe_o |-> !acc_q.write && !chip_select_n_i
	) else $error("data driven outside read");
	chk_ack_opendrain: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		ack_o == 1'b0
	) else $error("ack driven high");
	chk_ds_fast_lat: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && ds_mode && addr_i inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7} |-> ##4 in_ack
	) else $error("fast acknowledge timing");
	chk_sep_busy_low: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && !ds_mode |=> ack_oe_o
	) else $error("ready not low while busy");
	chk_sep_ready_high: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		in_ack && !ds_mode_q |-> !ack_oe_o
	) else $error("ready not released");
	chk_ds_ack_early: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && ds_mode |=> !ack_oe_o
	) else $error("acknowledge too early");
	chk_mode_latch: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start |=> ds_mode_q == $past(bus_mode_i)
	) else $error("mode not latched");
	chk_strobe_role: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && !ds_mode && data_strobe_n_i |=> acc_q.write
	) else $error("strobe role wrong");
	chk_reset_idle: assert property (
		@(posedge core_clk_i)
		!rst_n_i |=> state_q == DMPS_IDLE && !ack_oe_o && !port_data_oe_o
	) else $error("reset not idle");
	chk_read_capture: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_stb_o |=> in_ack && port_data_o == $past(core_rdata_i)
	) else $error("read data not captured");
	chk_ack_hold: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		in_ack && strobe_on |=> in_ack
	) else $error("acknowledge dropped early");
	chk_idle_quiet: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == DMPS_IDLE |-> !ack_oe_o && !port_data_oe_o
	) else $error("idle port drives");
	chk_wait_no_data: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == DMPS_WAIT |-> !port_data_oe_o
	) else $error("data driven while waiting");
	chk_sep_addr_five: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		start && !ds_mode && addr_i == 3'h5 |-> ##3 in_ack
	) else $error("address five ready late");
endmodule : dmps_port

// ===== core/dmps_defines.svh
// Constants for the dual mode microport slave.
`ifndef DMPS_DEFINES_SVH
`define DMPS_DEFINES_SVH
`define DMPS_CLK_PERIOD_NS    8
`define DMPS_LAT_FAST_CYC     3'h2
`define DMPS_LAT_MED_CYC      3'h3
`define DMPS_LAT_SLOW_CYC     3'h4
`define DMPS_MODE_DSTROBE     1'h1
`define DMPS_ADDR_MEDIUM      3'h4
`define DMPS_ADDR_SHARED      3'h5
`define DMPS_ADDR_RAMCTL      3'h0
`define DMPS_DATA_W           8
`define DMPS_ADDR_W           3
`endif

// ===== core/dmps_pkg.sv
// Types for the dual mode microport slave.
package dmps_pkg;
	typedef struct packed {
		logic [2:0] addr;
		logic       write;
		logic       ram;
	} dmps_access_t;
	typedef enum logic [1:0] {
		DMPS_IDLE = 2'b00,
		DMPS_WAIT = 2'b01,
		DMPS_ACK  = 2'b10
	} dmps_state_t;
endpackage : dmps_pkg

// ===== core/dmps_latency.sv
// Latency selector for an access, by mode, address and target.
`timescale 1ns/1ns
`include "dmps_defines.svh"
module dmps_latency
	import dmps_pkg::*;
(
	input  wire logic         mode_i,
	input  wire dmps_access_t acc_i,
	output logic [2:0]        lat_o
);
	wire is_ram  = (acc_i.addr == `DMPS_ADDR_RAMCTL) && acc_i.ram;
	wire is_med  = (acc_i.addr == `DMPS_ADDR_MEDIUM) || (acc_i.addr == `DMPS_ADDR_RAMCTL);
	wire med_ds  = is_med || (acc_i.addr == `DMPS_ADDR_SHARED);
	wire [2:0] base = is_ram ? `DMPS_LAT_SLOW_CYC : (is_med ? `DMPS_LAT_MED_CYC : `DMPS_LAT_FAST_CYC);
	wire [2:0] base_ds = is_ram ? `DMPS_LAT_SLOW_CYC : (med_ds ? `DMPS_LAT_MED_CYC : `DMPS_LAT_FAST_CYC);
	// Data strobe mode adds one cycle to every class.
	assign lat_o = (mode_i == `DMPS_MODE_DSTROBE) ? 3'(base_ds + 3'h1) : base;
endmodule : dmps_latency

// ===== verif/dmps_host.sv
// Host processor model that drives the microport.
`timescale 1ns/1ns
module dmps_host (
	input  wire logic        clk_i,
	input  wire logic        ack_n_i,
	input  wire logic [7:0]  dq_i,
	output logic             cs_n_o,
	output logic             ds_n_o,
	output logic             st_n_o,
	output logic [2:0]       a_o,
	output logic             ram_o,
	output logic [7:0]       d_o,
	output logic             vld_o,
	output logic [11:0]      res_o
);
	initial {cs_n_o, ds_n_o, st_n_o, a_o, ram_o, d_o, vld_o, res_o} = {3'h7, 12'h0, 1'h0, 12'h0};
	// One access; the result holds edge count to acknowledge and read data.
	task automatic acc(input logic m, w, c, input logic [2:0] a, input logic r, input logic [7:0] d);
		logic b = 0;
		int   n = 0;
		@(negedge clk_i);
		{cs_n_o, a_o, ram_o, d_o, ds_n_o, st_n_o} = {c, a, r, d, !(m | !w), !w};
		do begin
			@(posedge clk_i);
			#1 n++;
			if (m ? !ack_n_i : b & ack_n_i) break;
			b |= !ack_n_i;
		end while (n < 9);
		res_o = {n[3:0], w | c ? 8'h0 : dq_i};
		vld_o = 1'b1;
		@(negedge clk_i);
		{vld_o, cs_n_o, ds_n_o, st_n_o, d_o} = {4'h7, ~d_o};
		repeat (2) @(negedge clk_i);
	endtask : acc
endmodule : dmps_host

// ===== verif/dmps_port_test.sv
// Self-checking testbench for the microport slave.
`timescale 1ns/1ns
module dmps_port_test;
	logic        clk = 0, rst_n = 0, mode = 0, cs_n, ds_n, st_n, ram, poe, ack, aoe, wst, rstb, vld;
	logic [2:0]  a, ca, qr[$];
	logic [7:0]  d, pdo, cwd, rdat = 8'h00;
	logic [11:0] res, qa[$];
	logic [10:0] qw[$];
	int          n_errors = 0, checked = 0, seed = 21;
	always #4 clk = !clk;
	dmps_port dmps_port_inst (.core_clk_i(clk), .rst_n_i(rst_n), .bus_mode_i(mode), .chip_select_n_i(cs_n),
		.data_strobe_n_i(ds_n), .store_strobe_n_i(st_n), .addr_i(a), .ram_target_i(ram), .port_data_i(d),
		.port_data_o(pdo), .port_data_oe_o(poe), .ack_o(ack), .ack_oe_o(aoe), .wr_stb_o(wst), .rd_stb_o(rstb),
		.core_addr_o(ca), .core_wdata_o(cwd), .core_rdata_i(rdat));
	dmps_host dmps_host_inst (.clk_i(clk), .ack_n_i(aoe ? ack : 1'b1), .dq_i(poe ? pdo : ~rdat),
		.cs_n_o(cs_n), .ds_n_o(ds_n), .st_n_o(st_n), .a_o(a), .ram_o(ram), .d_o(d), .vld_o(vld), .res_o(res));
	task automatic cmp(input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task automatic cmp_acc(input logic [11:0] g, e);
		cmp(16'(g), 16'(e));
	endtask : cmp_acc
	task automatic cmp_wr(input logic [10:0] g, e);
		cmp(16'(g), 16'(e));
	endtask : cmp_wr
	task automatic cmp_rd(input logic [2:0] g, e);
		cmp(16'(g), 16'(e));
	endtask : cmp_rd
	always @(posedge vld) cmp_acc(res, qa.pop_front());
	always @(negedge clk) if (wst) cmp_wr({ca, cwd}, qw.pop_front());
	always @(negedge clk) if (rstb) cmp_rd(ca, qr.pop_front());
	task automatic go(input logic m, w, c, input logic [2:0] aa, input logic r);
		logic [3:0] l;
		logic [7:0] dd;
		dd = 8'($random(seed));
		rdat = 8'($random(seed));
		l = (aa == 3'h0 && r) ? 4'h5 : (aa == 3'h4 || aa == 3'h0 || (m && aa == 3'h5)) ? 4'h4 : 4'h3;
		l = c ? 4'h9 : l + 4'(m);
		qa.push_back({l, w | c ? 8'h00 : rdat});
		if (w && !c) qw.push_back({aa, dd});
		if (!w && !c) qr.push_back(aa);
		mode = m;
		dmps_host_inst.acc(m, w, c, aa, r, dd);
	endtask : go
	task automatic conclude;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 128; i++) go(i[5], i[4], i % 11 == 10, i[2:0], i[3]);
		repeat (4) @(negedge clk);
		cmp(16'(qa.size() + qw.size() + qr.size()), 16'h0000);
		conclude();
	end
	initial begin
		#40000;
		n_errors++;
		conclude();
	end
endmodule : dmps_port_test
